// *** design/lcd_drv_consts.vh ***
// constants for the multiplexed lcd controller and driver
// assumes a single 100 MHz clock and a 4-bit register port from the cpu
`ifndef LCD_DRV_CONSTS_VH
`define LCD_DRV_CONSTS_VH

// ============================================================
// register numbers and command register layout
`define REG_CMD          4'h3
`define REG_SHIFT        4'h6
`define CMD_SCAN         0
`define CMD_HOLD         1
`define CMD_RESET        2'h0
`define NIB_RESET        4'h0

// ============================================================
// geometry
`define NUM_SEG          24
`define NUM_COM          4
`define DISP_BITS        96
`define DISP_RESET       96'h0
`define LAST_COM_QUARTER 2'h3
`define LAST_COM_THIRD   2'h2
`define COM_FIRST        2'h0

// ============================================================
// common period: 2^m internal clocks, m = 9, internal clock = clk
`define COM_DIV_M        9
`define COM_PERIOD_CLKS  (1 << `COM_DIV_M)
`define COM_CNT_MAX      9'h1FF
`define COM_CNT_RESET    9'h000

// ============================================================
// drive level codes, 1/3 bias: vdd, 1/3, 2/3, lcd_supply_input
`define LVL_VDD          2'h0
`define LVL_V1           2'h1
`define LVL_V2           2'h2
`define LVL_LCD_SUPPLY_INPUT         2'h3

`endif

// *** design/lcd_level_map.v ***
// level selection for the common and segment drivers, 1/3 bias
// assumes the caller registers the outputs and forces vdd on supply cut
`timescale 1ns/10ps
`include "lcd_drv_consts.vh"

module lcd_level_map (
    input  wire [1:0]                  com_idx,   // active common line
    input  wire                        polarity,  // frame polarity
    input  wire                        blank,     // force segments dark
    input  wire [`DISP_BITS-1:0]       disp,      // held display words
    output wire [2*`NUM_COM-1:0]       com_lvl,   // 2-bit level per common
    output wire [2*`NUM_SEG-1:0]       seg_lvl    // 2-bit level per segment
);

    // ============================================================
    // level functions
    function [1:0] com_level;
        input sel;
        input pol;
        begin
            if (sel) begin
                com_level = pol ? `LVL_VDD : `LVL_LCD_SUPPLY_INPUT;
            end else begin
                com_level = pol ? `LVL_V2 : `LVL_V1;
            end
        end
    endfunction

    // a lit dot sees the full swing, a dark dot only one third of it
    function [1:0] seg_level;
        input on;
        input pol;
        begin
            if (on) begin
                seg_level = pol ? `LVL_LCD_SUPPLY_INPUT : `LVL_VDD;
            end else begin
                seg_level = pol ? `LVL_V1 : `LVL_V2;
            end
        end
    endfunction

    // ============================================================
    // drivers
    genvar g;
    generate
        for (g = 0; g < `NUM_COM; g = g + 1) begin : g_com
            assign com_lvl[2*g+1:2*g] = com_level(com_idx == g, polarity);
        end
        for (g = 0; g < `NUM_SEG; g = g + 1) begin : g_seg
            assign seg_lvl[2*g+1:2*g] = seg_level(disp[4*g + com_idx] & ~blank,
                                                  polarity);
        end
    endgenerate

endmodule

// *** design/lcd_segment_driver_controller.v ***
// lcd controller and driver of a 4-bit microcontroller
// assumes the cpu register port runs on clk; nrst is the initialize signal
//
// Function
// - two-bit command register, number 3, readable
// - initialize clears both command bits
// - four commons, 24 segments, one supply input
// - one-third or quarter duty, third bias
// - 96 segments quarter, 72 third duty
// - word bit j drives segment on common j
// - one lights the dot, zero dark
// - third duty scans commons 0-2 only
// - run zero: register 6 write shifts word
// - run one blocks shift, shows held data
// - common steps automatically each common period
// - load within one period: no blank
// - load spanning common switch: blank display
// - run one: register 6 writes aux port
// - initialize cuts supply, run bit restores
// - hold with run zero cuts everything
// - common period is 2^9 internal clocks
`timescale 1ns/10ps
`include "lcd_drv_consts.vh"

module lcd_segment_driver_controller #(
    parameter QUARTER_DUTY = 1              // mask option: 1 = 1/4 duty, 0 = 1/3
) (
    input  wire                  clk,              // 100 MHz clock
    input  wire                  nrst,             // initialize, async, active low
    input  wire [3:0]            reg_addr,         // register number
    input  wire [3:0]            reg_wdata,        // write data
    input  wire                  reg_wr,           // write strobe, one cycle
    input  wire                  reg_rd,           // read strobe, one cycle
    output reg  [3:0]            reg_rdata,        // read data, next cycle
    input  wire                  lcd_supply_input, // external supply present
    output reg                   lcd_supply_switch,// internal supply switch closed
    output reg  [3:0]            aux_output_nibble,// general output latch
    output reg  [2*`NUM_COM-1:0] common_lines,     // 2-bit level per common
    output reg  [2*`NUM_SEG-1:0] segment_lines     // 2-bit level per segment
);

    // ============================================================
    // register number decode, shared by the write and read paths
    function addr_hit;
        input [3:0] addr;
        input [3:0] num;
        begin
            addr_hit = (addr == num);
        end
    endfunction

    // ============================================================
    // state
    reg  [1:0]            cmd_reg;
    reg  [1:0]            cmd_next;
    reg  [`DISP_BITS-1:0] shift_reg;
    reg  [`DISP_BITS-1:0] disp_reg;
    reg                   switch_reg;
    reg                   blank_reg;
    reg                   blank_next;
    reg  [8:0]            div_reg;
    reg  [1:0]            com_reg;
    reg  [1:0]            com_next;
    reg                   pol_reg;
    reg                   sup_meta_reg;
    reg                   sup_sync_reg;

    wire                  scan = cmd_reg[`CMD_SCAN];
    wire                  hold = cmd_reg[`CMD_HOLD];
    wire                  wr_cmd = reg_wr && addr_hit(reg_addr, `REG_CMD);
    wire                  wr_six = reg_wr && addr_hit(reg_addr, `REG_SHIFT);
    wire                  scan_rise = wr_cmd && reg_wdata[`CMD_SCAN] && !scan;
    wire                  scan_fall = wr_cmd && !reg_wdata[`CMD_SCAN] && scan;
    wire                  com_tick = (div_reg == `COM_CNT_MAX);
    wire [1:0]            last_com = QUARTER_DUTY ? `LAST_COM_QUARTER : `LAST_COM_THIRD;
    wire                  cut = !switch_reg || (hold && !scan) || !sup_sync_reg;
    wire [2*`NUM_COM-1:0] com_lvl;
    wire [2*`NUM_SEG-1:0] seg_lvl;

    // ============================================================
    // command register
    always @* begin
        cmd_next = cmd_reg;
        if (wr_cmd) begin
            cmd_next = reg_wdata[1:0];
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_reg <= `CMD_RESET;
        end else begin
            cmd_reg <= cmd_next;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= `NIB_RESET;
        end else if (reg_rd) begin
            reg_rdata <= addr_hit(reg_addr, `REG_CMD) ? {2'b00, cmd_reg} : `NIB_RESET;
        end
    end

    // ============================================================
    // display data path
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_reg         <= `DISP_RESET;
            disp_reg          <= `DISP_RESET;
            aux_output_nibble <= `NIB_RESET;
        end else begin
            // shift one word in; first word ends at segment 23
            if (wr_six && !scan) begin
                shift_reg <= {shift_reg[`DISP_BITS-5:0], reg_wdata};
            end
            if (wr_six && scan) begin
                aux_output_nibble <= reg_wdata;
            end
            if (scan_rise) begin
                disp_reg <= shift_reg;
            end
        end
    end

    // ============================================================
    // supply switch and synchroniser
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            switch_reg   <= 1'b0;
            sup_meta_reg <= 1'b0;
            sup_sync_reg <= 1'b0;
        end else begin
            sup_meta_reg <= lcd_supply_input;
            sup_sync_reg <= sup_meta_reg;
            if (scan_rise) begin
                switch_reg <= 1'b1;
            end
        end
    end

    // ============================================================
    // common scan
    always @* begin
        com_next = com_reg;
        if (com_tick) begin
            com_next = (com_reg == last_com) ? `COM_FIRST : com_reg + 2'h1;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= `COM_CNT_RESET;
            com_reg <= `COM_FIRST;
            pol_reg <= 1'b0;
        end else begin
            div_reg <= com_tick ? `COM_CNT_RESET : div_reg + 9'h001;
            com_reg <= com_next;
            if (com_tick && (com_reg == last_com)) begin
                pol_reg <= !pol_reg;
            end
        end
    end

    // ============================================================
    // blanking across a common switch
    // a load that sees no tick keeps the old picture up, so it never flickers
    always @* begin
        blank_next = blank_reg;
        if (com_tick && !scan) begin
            blank_next = 1'b1;
        end else if (scan_fall) begin
            blank_next = 1'b0;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blank_reg <= 1'b0;
        end else begin
            blank_reg <= blank_next;
        end
    end

    // ============================================================
    // drivers
    lcd_level_map u_map (
        .com_idx  (com_reg),
        .polarity (pol_reg),
        .blank    (blank_reg && !scan),
        .disp     (disp_reg),
        .com_lvl  (com_lvl),
        .seg_lvl  (seg_lvl)
    );

    // outputs registered so the pins never glitch between levels
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lcd_supply_switch <= 1'b0;
            common_lines      <= {2*`NUM_COM{1'b0}};
            segment_lines     <= {2*`NUM_SEG{1'b0}};
        end else begin
            lcd_supply_switch <= !cut;
            // cut drives all lines to vdd
            common_lines      <= cut ? {2*`NUM_COM{1'b0}} : com_lvl;
            segment_lines     <= cut ? {2*`NUM_SEG{1'b0}} : seg_lvl;
        end
    end

endmodule

// *** test/lcd_drv_sva.sv ***
// ==========================================
// port checker for the lcd controller and driver
// assumes one clk domain and async active-low nrst
`timescale 1ns/10ps
module lcd_drv_sva (
    input wire        clk,               // clock
    input wire        nrst,              // initialize
    input wire [3:0]  reg_addr,          // register number
    input wire [3:0]  reg_wdata,         // write data
    input wire        reg_wr,            // write strobe
    input wire        reg_rd,            // read strobe
    input wire [3:0]  reg_rdata,         // read data
    input wire        lcd_supply_input,  // supply present
    input wire        lcd_supply_switch, // supply connected
    input wire [3:0]  aux_output_nibble, // output latch
    input wire [7:0]  common_lines,      // common levels
    input wire [47:0] segment_lines      // segment levels
);
// free count in step with the common divider
reg [8:0] cnt_reg;
always @(posedge clk or negedge nrst)
    if (!nrst) cnt_reg <= 9'h000;
    else cnt_reg <= cnt_reg + 9'h001;
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
cut_to_vdd_a: assert property (
    !lcd_supply_switch |-> common_lines == 8'h00 && segment_lines == 48'h0)
    else $error("lines not at vdd while supply cut");
rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
rd_other_a: assert property (
    reg_rd && reg_addr != 4'h3 |=> reg_rdata == 4'h0)
    else $error("unmapped read not zero");
cmd_back_a: assert property (
    reg_wr && reg_addr == 4'h3 ##1 reg_rd && !reg_wr && reg_addr == 4'h3
    |=> reg_rdata == {2'h0, $past(reg_wdata[1:0], 2)})
    else $error("command readback wrong");
aux_hold_a: assert property (
    !(reg_wr && reg_addr == 4'h6) |=> $stable(aux_output_nibble))
    else $error("aux latch moved without write");
com_step_a: assert property (
    $changed(common_lines) && lcd_supply_switch && $past(lcd_supply_switch)
    |-> cnt_reg == 9'h001)
    else $error("common stepped off the 512 clock grid");
com_sel_a: assert property (
    lcd_supply_switch && common_lines[1:0] == 2'h3 |-> common_lines[7:2] == 6'h15)
    else $error("unselected common level wrong");
seg_pol_a: assert property (
    lcd_supply_switch && common_lines[1:0] == 2'h3
    |-> (segment_lines & 48'h555555555555) == 48'h0)
    else $error("segment level wrong for polarity");
supply_on_a: assert property (
    reg_wr && reg_addr == 4'h3 && reg_wdata[0] && lcd_supply_input |-> ##2 lcd_supply_switch)
    else $error("run bit did not connect supply");
cover property (reg_wr && reg_addr == 4'h6 && !lcd_supply_switch);
cover property ($changed(common_lines) && lcd_supply_switch);
cover property (reg_rd && reg_addr == 4'h3);
endmodule
bind lcd_segment_driver_controller lcd_drv_sva u_sva (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lcd_supply_input(lcd_supply_input),
    .lcd_supply_switch(lcd_supply_switch), .aux_output_nibble(aux_output_nibble),
    .common_lines(common_lines), .segment_lines(segment_lines));

// *** test/lcd_panel_model.sv ***
// ==========================================
// panel model: decodes which dots see full drive
// assumes level codes 0 and 3 are the outer levels
`timescale 1ns/10ps
module lcd_panel_model (
    input  wire [7:0]  common_lines,     // common levels
    input  wire [47:0] segment_lines,    // segment levels
    output reg         lcd_supply_input, // supply present
    output reg         active,           // a common is selected
    output reg  [1:0]  sel_com,          // selected common
    output reg  [23:0] lit               // dots lit on it
);
integer   k;
reg [1:0] cl;
initial lcd_supply_input = 1'b1;
always @* begin
    active = 1'b0;
    sel_com = 2'h0;
    cl = 2'h0;
    for (k = 0; k < 4; k = k + 1)
        if (common_lines[2*k] == common_lines[2*k+1] && common_lines != 8'h00) begin
            active = 1'b1;
            sel_com = k[1:0];
            cl = common_lines[2*k+:2];
        end
    for (k = 0; k < 24; k = k + 1)
        lit[k] = active && segment_lines[2*k+:2] == ~cl;
end
endmodule

// *** test/tb_lcd_segment_driver_controller.sv ***
// ==========================================
// self-checking bench for the lcd controller and driver
// assumes the panel model provides the supply input
`timescale 1ns/10ps
module tb_lcd_segment_driver_controller;
reg         clk, nrst, reg_wr, reg_rd;
reg  [3:0]  reg_addr, reg_wdata;
wire [3:0]  reg_rdata, aux;
wire        sup_in, sup_sw, act;
wire [7:0]  com, com3;
wire [47:0] seg;
wire [1:0]  sel;
wire [23:0] lit;
integer     mismatches, total_checks, i, n;
lcd_segment_driver_controller DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lcd_supply_input(sup_in), .lcd_supply_switch(sup_sw), .aux_output_nibble(aux),
    .common_lines(com), .segment_lines(seg));
// third-duty twin on the same bus, to see the shorter scan
lcd_segment_driver_controller #(.QUARTER_DUTY(0)) DUT3 (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(), .lcd_supply_input(sup_in), .lcd_supply_switch(),
    .aux_output_nibble(), .common_lines(com3), .segment_lines());
lcd_panel_model panel (.common_lines(com), .segment_lines(seg),
    .lcd_supply_input(sup_in), .active(act), .sel_com(sel), .lit(lit));
// ==========================================
// helpers
function [23:0] exp_lit(input [1:0] j, input [3:0] x);
    integer   k;
    reg [3:0] w;
    begin
        for (k = 0; k < 24; k = k + 1) begin
            w = k[3:0] * 4'h5 + 4'h3;
            exp_lit[k] = w[j] ^ x[j];
        end
    end
endfunction
task stop_test;
    begin
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
endtask
task chk(input [63:0] seen, input [63:0] exp, input [8*8-1:0] what);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch %0s exp %h seen %h", what, exp, seen);
        end
    end
endtask
// strobes stay up between back-to-back requests; quiet drops them
task wr(input [3:0] a, input [3:0] d);
    begin
        reg_rd = 1'b0;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
    end
endtask
task rd(input [3:0] a, input [3:0] e);
    begin
        reg_wr = 1'b0;
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        chk(reg_rdata, e, "rdata");
    end
endtask
task quiet(input integer c);
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (c) @(negedge clk);
    end
endtask
task wait_com(input [1:0] j);
    integer c;
    begin
        c = 0;
        while (!(act === 1'b1 && sel === j) && c < 2100) begin
            @(negedge clk);
            c = c + 1;
        end
        if (c == 2100) begin
            mismatches = mismatches + 1;
            stop_test;
        end
    end
endtask
task load(input [3:0] x);
    begin
        wr(4'h3, 4'h0);
        for (i = 23; i >= 0; i = i - 1)
            wr(4'h6, (i[3:0] * 4'h5 + 4'h3) ^ x);
        wr(4'h3, 4'h1);
        quiet(3);
    end
endtask
// ==========================================
// scenarios
task t_reset;
    begin
        chk(sup_sw, 1'b0, "supply");
        chk({com, seg}, 56'h0, "lines");
        rd(4'h3, 4'h0);
    end
endtask
task t_cmd;
    begin
        wr(4'h3, 4'hF);
        rd(4'h3, 4'h3);
        rd(4'h5, 4'h0);
        wr(4'h3, 4'h2);
        quiet(3);
        chk(sup_sw, 1'b0, "supply");
        chk({com, seg}, 56'h0, "lines");
    end
endtask
task t_load;
    begin
        load(4'h0);
        chk(sup_sw, 1'b1, "supply");
        for (n = 0; n < 4; n = n + 1) begin
            wait_com(n[1:0]);
            chk(lit, exp_lit(n[1:0], 4'h0), "dots");
        end
        chk(com3, 8'hA8, "third");
    end
endtask
task t_aux;
    begin
        wr(4'h6, 4'hA);
        quiet(2);
        chk(aux, 4'hA, "aux");
        wr(4'h3, 4'h0);
        wr(4'h3, 4'h1);
        quiet(3);
        wait_com(2'h1);
        chk(lit, exp_lit(2'h1, 4'h0), "dots");
    end
endtask
task t_blank;
    begin
        wr(4'h3, 4'h0);
        quiet(600);
        chk(lit, 24'h0, "blank");
        chk(sup_sw, 1'b1, "supply");
        wr(4'h3, 4'h1);
        quiet(3);
    end
endtask
task t_noblank;
    begin
        wait_com(2'h3);
        wait_com(2'h0);
        wr(4'h3, 4'h0);
        quiet(2);
        chk(lit, exp_lit(2'h0, 4'h0), "noblank");
        load(4'hF);
        chk(lit, exp_lit(2'h0, 4'hF), "swap");
    end
endtask
task t_short;
    begin
        wr(4'h3, 4'h0);
        wr(4'h6, 4'h1);
        wr(4'h6, 4'h2);
        wr(4'h3, 4'h1);
        quiet(3);
        wait_com(2'h1);
        chk(lit[1:0], 2'h1, "short");
    end
endtask
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 4'h0;
    mismatches = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_reset;
    t_cmd;
    t_load;
    t_aux;
    t_blank;
    t_noblank;
    t_short;
    stop_test;
end
endmodule
